// file: include/keyint_pkg.sv
// constants shared by the keyboard interrupt block
package keyint_pkg;
   localparam int          KEY_PINS       = 8;
   localparam int          AXI_ADDR_W     = 8;
   localparam int          AXI_DATA_W     = 32;
   // printed register indices; byte address is four times the index
   localparam logic [7:0]  IDX_STATUS_CTL = 8'h1A;
   localparam logic [7:0]  IDX_PIN_ENABLE = 8'h1B;
   localparam logic [7:0]  ADDR_STATUS_CTL = 8'h68;
   localparam logic [7:0]  ADDR_PIN_ENABLE = 8'h6C;
   // status and control field positions
   localparam int          BIT_PENDING    = 3;
   localparam int          BIT_ACK        = 2;
   localparam int          BIT_MASK       = 1;
   localparam int          BIT_LEVEL      = 0;
   // reset values
   localparam logic [7:0]  RST_PIN_ENABLE = 8'h00;
   localparam logic        RST_MASK       = 1'b0;
   localparam logic        RST_LEVEL      = 1'b0;
   localparam logic [7:0]  RST_SYNC       = 8'hFF;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [1:0]
   {
      SEL_NONE   = 2'h0,
      SEL_STATUS = 2'h1,
      SEL_ENABLE = 2'h2
   } keyint_sel_e;
endpackage

// file: core/keyint_core.sv
// keyboard interrupt block with AXI4-Lite register access
`timescale 1ns/100ps

// Behaviour
// - one enable bit per key pin selects its part in detection
// - an enabled key pin also gets its pull-up switched on
// - request latches when enabled pins go low after all were high
// - edge-only mode ignores a fall while another enabled pin is low
// - level mode keeps request while any enabled pin is low
// - level mode clears after acknowledge and all pins high, any order
// - vector fetch acknowledges like the software acknowledge bit, but is never blocked in break
// - writing one to acknowledge bit clears request; bit reads zero
// - acknowledge does not block a later fall from latching again
// - latched unmasked request goes to the CPU for its vector
// - edge-only mode: acknowledge clears request at once
// - reset clears request latch and level select even with pin low
// - pending flag shows latched request regardless of mask
// - enabled key pin is forced to input over its direction bit
// - mask bit one blocks request to CPU, zero passes it
// - level select zero means edge only, one edge plus low level
// - pin enable register is read/write and cleared by reset
// - active in wait mode; unmasked request wakes the processor
// - active in stop mode; unmasked request wakes the processor
// - in break, acknowledge writes ignored unless break clear enabled
module keyint_core
   import keyint_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [AXI_ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic [2:0]              s_axi_awprot,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [AXI_DATA_W-1:0]   s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0]   s_axi_araddr,
   input  wire logic [2:0]              s_axi_arprot,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [AXI_DATA_W-1:0]        s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   input  wire logic [KEY_PINS-1:0]     keyPins,
   input  wire logic [KEY_PINS-1:0]     portDirOut,
   output logic [KEY_PINS-1:0]          portDriveEn,
   output logic [KEY_PINS-1:0]          keyPullupEn,
   input  wire logic                    vectorFetch,
   input  wire logic                    breakState,
   input  wire logic                    breakClearEnable,
   output logic                         keyIrq,
   output logic                         keyWake
);

   function automatic keyint_sel_e regSel(input logic [AXI_ADDR_W-1:0] a);
      if (a == ADDR_STATUS_CTL)
         return SEL_STATUS;
      else if (a == ADDR_PIN_ENABLE)
         return SEL_ENABLE;
      else
         return SEL_NONE;
   endfunction

   logic [KEY_PINS-1:0]   syncA_q;
   logic [KEY_PINS-1:0]   syncB_q;
   logic [KEY_PINS-1:0]   keyPinEnable_q;
   logic                  keyMask_q;
   logic                  keyLevelSel_q;
   logic                  reqLatch_q;
   logic                  reqLatch_d;
   logic                  ackPend_q;
   logic                  ackPend_d;
   logic                  prevAnyLow_q;
   logic                  awHeld_q;
   logic [AXI_ADDR_W-1:0] awAddr_q;
   logic                  wHeld_q;
   logic [7:0]            wData_q;
   logic                  wLane0_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   logic                  rvalid_q;
   logic [AXI_DATA_W-1:0] rdata_q;
   logic [1:0]            rresp_q;

   // two-stage synchroniser per pin; idle high matches the pull-up
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         syncA_q <= RST_SYNC;
         syncB_q <= RST_SYNC;
      end
      else
      begin
         syncA_q <= keyPins;
         syncB_q <= syncA_q;
      end
   end

   // detection
   wire [KEY_PINS-1:0] pinLow   = ~syncB_q & keyPinEnable_q;
   wire                anyLow   = |pinLow;
   wire                edgeEvt  = anyLow & ~prevAnyLow_q;

   // register bus decode
   wire                doWrite  = awHeld_q & wHeld_q & ~bvalid_q;
   wire keyint_sel_e   wSel     = regSel(awAddr_q);
   wire                wrStatus = doWrite & wLane0_q & (wSel == SEL_STATUS);
   wire                wrEnable = doWrite & wLane0_q & (wSel == SEL_ENABLE);
   wire                arTake   = s_axi_arvalid & ~rvalid_q;
   wire keyint_sel_e   rSel     = regSel(s_axi_araddr);
   wire                swAck    = wrStatus & wData_q[BIT_ACK];
   wire                ackAllow = ~breakState | breakClearEnable;
   wire                ackEvt   = vectorFetch | (swAck & ackAllow);
   wire                ackDone  = ackEvt | ackPend_q;

   // set wins over clear in both modes
   wire latchEdge  = edgeEvt | (reqLatch_q & ~ackEvt);
   wire latchLevel = anyLow | (reqLatch_q & ~ackDone);
   assign reqLatch_d = keyLevelSel_q ? latchLevel : latchEdge;
   // remembers an acknowledge taken while enabled pins are still low
   assign ackPend_d  = keyLevelSel_q & reqLatch_d & ackDone & anyLow;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         reqLatch_q   <= 1'b0;
         ackPend_q    <= 1'b0;
         prevAnyLow_q <= 1'b0;
      end
      else
      begin
         reqLatch_q   <= reqLatch_d;
         ackPend_q    <= ackPend_d;
         prevAnyLow_q <= anyLow;
      end
   end

   // software registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         keyPinEnable_q <= RST_PIN_ENABLE;
         keyMask_q      <= RST_MASK;
         keyLevelSel_q  <= RST_LEVEL;
      end
      else
      begin
         if (wrEnable)
            keyPinEnable_q <= wData_q;
         if (wrStatus)
         begin
            keyMask_q     <= wData_q[BIT_MASK];
            keyLevelSel_q <= wData_q[BIT_LEVEL];
         end
      end
   end

   // pin side outputs
   assign keyPullupEn = keyPinEnable_q;
   assign portDriveEn = portDirOut & ~keyPinEnable_q;
   assign keyIrq      = reqLatch_q & ~keyMask_q;
   // runs on the bus clock, which must keep running in stop mode
   assign keyWake     = keyIrq;

   // write channel: address and data accepted in either order
   assign s_axi_awready = ~awHeld_q;
   assign s_axi_wready  = ~wHeld_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   // write address holder
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
      end
      else if (s_axi_awvalid & ~awHeld_q)
      begin
         awHeld_q <= 1'b1;
         awAddr_q <= s_axi_awaddr;
      end
      else if (doWrite)
         awHeld_q <= 1'b0;
   end

   // write data holder; only the low byte lane carries a register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wHeld_q  <= 1'b0;
         wData_q  <= 8'h00;
         wLane0_q <= 1'b0;
      end
      else if (s_axi_wvalid & ~wHeld_q)
      begin
         wHeld_q  <= 1'b1;
         wData_q  <= s_axi_wdata[7:0];
         wLane0_q <= s_axi_wstrb[0];
      end
      else if (doWrite)
         wHeld_q <= 1'b0;
   end

   // write response; unmapped addresses answer with an error
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end
      else if (doWrite)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   // read channel
   wire [7:0] statusRead = {4'h0, reqLatch_q, 1'b0, keyMask_q,
                            keyLevelSel_q};
   wire [7:0] readByte   = (rSel == SEL_STATUS) ? statusRead :
                           (rSel == SEL_ENABLE) ? keyPinEnable_q : 8'h00;

   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end
      else if (arTake)
      begin
         rvalid_q <= 1'b1;
         rdata_q  <= {24'h000000, readByte};
         rresp_q  <= (rSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_fall_sets_latch: assert property (edgeEvt |=> reqLatch_q)
      else $error("falling edge did not latch request");
   a_edge_blocked_low: assert property (
      (!keyLevelSel_q && prevAnyLow_q && !reqLatch_q) |=> !reqLatch_q)
      else $error("edge latched while another pin was low");
   a_level_holds_low: assert property (
      (keyLevelSel_q && anyLow) |=> reqLatch_q)
      else $error("level request dropped while pin low");
   a_level_needs_ack: assert property (
      (keyLevelSel_q && reqLatch_q && !ackDone) |=> reqLatch_q)
      else $error("level request cleared without acknowledge");
   a_edge_ack_clears: assert property (
      (!keyLevelSel_q && ackEvt && !edgeEvt) |=> !reqLatch_q)
      else $error("edge mode acknowledge did not clear");
   a_vector_ack_clears: assert property (
      (vectorFetch && !keyLevelSel_q && !edgeEvt) ##1 !edgeEvt
      |=> !reqLatch_q)
      else $error("vector fetch did not clear request");
   a_break_blocks_ack: assert property (
      (breakState && !breakClearEnable && !vectorFetch && reqLatch_q
       && !keyLevelSel_q) |=> reqLatch_q)
      else $error("acknowledge acted during protected break");
   a_ack_reads_zero: assert property (
      (arTake && rSel == SEL_STATUS) |=> !s_axi_rdata[BIT_ACK]
      && (s_axi_rdata[BIT_PENDING] == $past(reqLatch_q)))
      else $error("status read wrong");
   a_irq_needs_unmask: assert property (
      $rose(keyIrq) |-> !keyMask_q && reqLatch_q)
      else $error("interrupt raised while masked");
   a_pin_forced_input: assert property (
      (keyPinEnable_q & portDriveEn) == 8'h00)
      else $error("enabled key pin still driven");
   a_reset_clears: assert property (@(posedge clk) disable iff (1'b0)
      rst |=> !reqLatch_q && !keyLevelSel_q)
      else $error("reset did not clear latch");

   // detection path
   a_disabled_pin_quiet: assert property (
      (!reqLatch_q && !anyLow) |=> !reqLatch_q)
      else $error("request latched with no enabled pin low");
   a_sync_two_stage: assert property (
      (!$past(rst) && !$past(rst, 2)) |-> syncB_q == $past(keyPins, 2))
      else $error("key pin did not pass two stages");
   a_edge_relatch: assert property (
      (!keyLevelSel_q && edgeEvt && ackEvt) |=> reqLatch_q)
      else $error("fresh fall lost to acknowledge");
   a_ack_pend_clear: assert property (
      (keyLevelSel_q && ackPend_q && !anyLow) |=> !reqLatch_q)
      else $error("level request stayed after ack and release");

   // request and pull-up outputs
   a_irq_unmasked: assert property (
      (reqLatch_q && !keyMask_q) |-> keyIrq)
      else $error("unmasked request not presented");
   a_masked_quiet: assert property (
      keyMask_q |-> !keyIrq)
      else $error("masked request reached the processor");
   a_wake_follows: assert property (
      keyWake == keyIrq)
      else $error("wake does not follow request");
   a_pullup_follows: assert property (
      keyPullupEn == keyPinEnable_q)
      else $error("pull-up does not follow pin enable");

   // software registers
   a_enable_write: assert property (
      wrEnable |=> keyPinEnable_q == $past(wData_q))
      else $error("pin enable write lost");
   a_mask_update: assert property (
      wrStatus |=> keyMask_q == $past(wData_q[BIT_MASK]))
      else $error("mask write lost");
   a_level_update: assert property (
      wrStatus |=> keyLevelSel_q == $past(wData_q[BIT_LEVEL]))
      else $error("level select write lost");

   // register bus handshakes
   a_write_answers: assert property (
      doWrite |=> s_axi_bvalid)
      else $error("write got no response");
   a_read_answers: assert property (
      arTake |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
      else $error("read got no data");
   a_bvalid_holds: assert property (
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid
      && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rvalid_holds: assert property (
      (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid
      && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_write_err_resp: assert property (
      (doWrite && wSel == SEL_NONE) |=> s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   a_read_err_resp: assert property (
      (arTake && rSel == SEL_NONE) |=> s_axi_rresp == RESP_SLVERR)
      else $error("unmapped read not refused");

   c_edge_request: cover property (!keyLevelSel_q && edgeEvt ##1 keyIrq);
   c_level_clear: cover property (keyLevelSel_q && reqLatch_q && ackEvt
      && anyLow ##[1:50] !reqLatch_q);
   c_break_ignored: cover property (swAck && breakState
      && !breakClearEnable && reqLatch_q);
   c_bus_write: cover property (wrEnable ##1 keyPinEnable_q != 8'h00);
   c_vector_ack: cover property (vectorFetch && reqLatch_q
      ##1 !reqLatch_q);

endmodule

// file: sim/keyint_keypad.sv
// keypad switch model driving the key pins
`timescale 1ns/100ps
module keyint_keypad
   import keyint_pkg::*;
(
   input  wire logic                clk,
   input  wire logic [KEY_PINS-1:0] pressed,
   input  wire logic [KEY_PINS-1:0] pullupEn,
   output logic      [KEY_PINS-1:0] pins
);
   logic [KEY_PINS-1:0] floatLvl_q = 8'h55;
   // an open pin with no pull-up wanders every cycle
   always @(posedge clk)
      floatLvl_q <= ~floatLvl_q;
   // a closed switch pulls to ground, else the pull-up wins
   assign pins = ~pressed & (pullupEn | floatLvl_q);
endmodule

// file: sim/keyint_core_tb_top.sv
// self-checking bench of the keyboard interrupt block
`timescale 1ns/100ps
module keyint_core_tb_top
   import keyint_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, pressed = 8'h00;
   logic [7:0] dirOut = 8'hFF, pins, driveEn, pullEn;
   logic [31:0] wdata = 32'h0, rdata, rdV;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, vf = 1'b0;
   logic brk = 1'b0, bce = 1'b0, awready, wready, bvalid;
   logic arready, rvalid, irq, wake;
   logic [1:0] bresp, rresp, rs;
   int error_cnt = 0, num_checks = 0, cyc = 0;
   always #50 clk = ~clk;
   keyint_keypad i_pad (.clk(clk), .pressed(pressed), .pullupEn(pullEn),
      .pins(pins));
   keyint_core i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .keyPins(pins), .portDirOut(dirOut),
      .portDriveEn(driveEn), .keyPullupEn(pullEn), .vectorFetch(vf),
      .breakState(brk), .breakClearEnable(bce), .keyIrq(irq),
      .keyWake(wake));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rdV = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic stat(input logic [7:0] e);
      rd(ADDR_STATUS_CTL);
      chk("status", {24'h000000, e}, rdV);
   endtask
   // pins need two sync stages plus the latch edge
   task automatic key(input logic [7:0] p);
      @(posedge clk);
      pressed <= p;
      repeat (5) @(posedge clk);
   endtask
   task automatic t_reset();
      chk("pullup", 32'h0, 32'(pullEn));
      stat(8'h00);
      rd(ADDR_PIN_ENABLE);
      chk("enable", 32'h0, rdV);
      rd(8'h70);
      chk("rresp", 32'(RESP_SLVERR), 32'(rs));
      wr(8'h70, 8'hFF);
      chk("bresp", 32'(RESP_SLVERR), 32'(rs));
      $display("reset test done");
   endtask
   task automatic t_init();
      wr(ADDR_STATUS_CTL, 8'h02);
      wr(ADDR_PIN_ENABLE, 8'hFF);
      wr(ADDR_STATUS_CTL, 8'h06);
      wr(ADDR_STATUS_CTL, 8'h00);
      chk("pullup", 32'hFF, 32'(pullEn));
      chk("drive", 32'h0, 32'(driveEn));
      rd(ADDR_PIN_ENABLE);
      chk("enable", 32'hFF, rdV);
      stat(8'h00);
      $display("init test done");
   endtask
   task automatic t_edge();
      key(8'h01);
      chk("irq", 32'h1, 32'(irq));
      chk("wake", 32'h1, 32'(wake));
      stat(8'h08);
      wr(ADDR_STATUS_CTL, 8'h04);
      chk("irq", 32'h0, 32'(irq));
      key(8'h03);
      chk("irq", 32'h0, 32'(irq));
      key(8'h00);
      key(8'h04);
      chk("irq", 32'h1, 32'(irq));
      wr(ADDR_STATUS_CTL, 8'h02);
      chk("irq", 32'h0, 32'(irq));
      stat(8'h0A);
      @(posedge clk);
      vf <= 1'b1;
      @(posedge clk);
      vf <= 1'b0;
      stat(8'h02);
      wr(ADDR_STATUS_CTL, 8'h00);
      key(8'h00);
      $display("edge test done");
   endtask
   task automatic t_level();
      wr(ADDR_STATUS_CTL, 8'h01);
      key(8'h10);
      chk("irq", 32'h1, 32'(irq));
      wr(ADDR_STATUS_CTL, 8'h05);
      chk("irq", 32'h1, 32'(irq));
      chk("wake", 32'h1, 32'(wake));
      key(8'h00);
      chk("irq", 32'h0, 32'(irq));
      key(8'h10);
      key(8'h00);
      chk("irq", 32'h1, 32'(irq));
      wr(ADDR_STATUS_CTL, 8'h05);
      chk("irq", 32'h0, 32'(irq));
      stat(8'h01);
      $display("level test done");
   endtask
   task automatic t_break();
      wr(ADDR_STATUS_CTL, 8'h00);
      brk <= 1'b1;
      key(8'h01);
      wr(ADDR_STATUS_CTL, 8'h04);
      chk("irq", 32'h1, 32'(irq));
      bce <= 1'b1;
      wr(ADDR_STATUS_CTL, 8'h04);
      chk("irq", 32'h0, 32'(irq));
      brk <= 1'b0;
      bce <= 1'b0;
      repeat (3) @(posedge clk);
      chk("irq", 32'h0, 32'(irq));
      key(8'h00);
      $display("break test done");
   endtask
   task automatic t_pins();
      wr(ADDR_PIN_ENABLE, 8'h01);
      key(8'h20);
      chk("irq", 32'h0, 32'(irq));
      chk("pullup", 32'h01, 32'(pullEn));
      chk("drive", 32'hFE, 32'(driveEn));
      dirOut <= 8'h0F;
      @(posedge clk);
      chk("drive", 32'h0E, 32'(driveEn));
      wr(ADDR_STATUS_CTL, 8'h01);
      key(8'h21);
      chk("irq", 32'h1, 32'(irq));
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("irq", 32'h0, 32'(irq));
      stat(8'h00);
      chk("drive", 32'h0F, 32'(driveEn));
      $display("pin and reset test done");
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_init();
      t_edge();
      t_level();
      t_break();
      t_pins();
      report_and_stop();
   end
endmodule
